// File: logic/link_event_regs.sv
`timescale 1ns/1ns
`default_nettype none
module link_event_regs #(
    parameter int unsigned OVERLONG_CYC = link_evt_pkg::OVERLONG_CYC
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire link_evt_pkg::bus_req_t bus_req_in,
    output logic [31:0] rd_data_out,
    output logic irq_out,
    output logic [31:0] chan_recv_allow_out,
    output logic root_timing_source_enable_out,
    input wire logic [31:0] evt_src_in,
    input wire logic phy_readback_arrived_in,
    input wire logic [31:0] halt_src_in,
    input wire logic cyc_start_tx_in,
    input wire logic subaction_gap_end_in,
    input wire logic rx_cycle_start_in,
    input wire logic [31:0] rx_cycle_stamp_in,
    input wire logic [31:0] local_cycle_timer_in,
    input wire logic [31:0] iso_rx_ctx_evt_in,
    input wire logic [31:0] iso_rx_ctx_ena_in,
    input wire logic [31:0] iso_tx_ctx_evt_in,
    input wire logic [31:0] iso_tx_ctx_ena_in,
    input wire logic maker_defined_flag_in
);

    link_evt_pkg::evt_state_t st_ff;
    link_evt_pkg::evt_state_t nxt_st;

    logic [31:0] hw_lvl;
    logic [31:0] rise;
    logic [31:0] pulses;
    logic [31:0] blocked;
    logic [31:0] hw_set;
    logic [31:0] sw_set;
    logic [31:0] sw_clr;
    logic [31:0] ev_next;
    logic [31:0] ev_view;
    logic [31:0] lc_set;
    logic [31:0] lc_clr;
    logic overlong_pulse;
    logic mismatch;
    logic rx_sum;
    logic tx_sum;
    logic wr;
    logic rd;
    logic hit_fs;
    logic hit_fc;
    logic hit_es;
    logic hit_ec;
    logic hit_en;
    logic hit_ls;
    logic hit_lc;

    // ==========================================================
    // Address decode
    assign wr = bus_req_in.wr;
    assign rd = bus_req_in.rd;
    assign hit_fs = bus_req_in.addr == link_evt_pkg::FILT_SET_OFS;
    assign hit_fc = bus_req_in.addr == link_evt_pkg::FILT_CLR_OFS;
    assign hit_es = bus_req_in.addr == link_evt_pkg::EV_SET_OFS;
    assign hit_ec = bus_req_in.addr == link_evt_pkg::EV_CLR_OFS;
    assign hit_en = bus_req_in.addr == link_evt_pkg::ENA_OFS;
    assign hit_ls = bus_req_in.addr == link_evt_pkg::LCTL_SET_OFS;
    assign hit_lc = bus_req_in.addr == link_evt_pkg::LCTL_CLR_OFS;

    // ==========================================================
    // Event sources
    // Level sources go through edge detection; the halt is any context
    always_comb begin
        hw_lvl = evt_src_in & link_evt_pkg::GEN_SRC_MASK;
        hw_lvl[link_evt_pkg::PHY_RB_BIT] = phy_readback_arrived_in;
        hw_lvl[link_evt_pkg::FATAL_BIT] = |halt_src_in;
    end

    rise_bank u_rise (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .ce_in(ce_in),
        .lvl_in(hw_lvl),
        .rise_out(rise)
    );

    overlong_watch #(
        .LIMIT(OVERLONG_CYC)
    ) u_olc (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .ce_in(ce_in),
        .arm_in(st_ff.root_en),
        .start_in(cyc_start_tx_in),
        .gap_end_in(subaction_gap_end_in),
        .expired_out(overlong_pulse)
    );

    // Stamp compare is only valid in the cycle the stamp is offered
    assign mismatch = rx_cycle_start_in
        && (link_evt_pkg::timer_key(rx_cycle_stamp_in)
            != link_evt_pkg::timer_key(local_cycle_timer_in));

    // Summaries are live, never stored
    assign rx_sum = |(iso_rx_ctx_evt_in & iso_rx_ctx_ena_in);
    assign tx_sum = |(iso_tx_ctx_evt_in & iso_tx_ctx_ena_in);

    // ==========================================================
    // Visible event word
    always_comb begin
        ev_view = st_ff.ev & link_evt_pkg::LATCH_MASK;
        ev_view[link_evt_pkg::RX_SUM_BIT] = rx_sum;
        ev_view[link_evt_pkg::TX_SUM_BIT] = tx_sum;
        ev_view[link_evt_pkg::MAKER_BIT] = maker_defined_flag_in;
    end

    // ==========================================================
    // Event register next value
    // Halted contexts stay quiet until software clears the fatal flag
    always_comb begin
        blocked = st_ff.ev[link_evt_pkg::FATAL_BIT] ? st_ff.culprit : '0;
        blocked[link_evt_pkg::FATAL_BIT] = 1'b0;
        pulses = rise;
        pulses[link_evt_pkg::OVERLONG_BIT] = overlong_pulse;
        pulses[link_evt_pkg::MISMATCH_BIT] = mismatch;
        hw_set = pulses & link_evt_pkg::LATCH_MASK & ~blocked;
        sw_set = (wr && hit_es) ? (bus_req_in.wdata & link_evt_pkg::LATCH_MASK) : '0;
        sw_clr = (wr && hit_ec) ? (bus_req_in.wdata & link_evt_pkg::LATCH_MASK) : '0;
        ev_next = link_evt_pkg::w1sc(st_ff.ev, sw_set | hw_set, sw_clr);
        if (ev_next[link_evt_pkg::REINIT_BIT] && !st_ff.ev[link_evt_pkg::REINIT_BIT]) begin
            ev_next[link_evt_pkg::IDENT_BIT] = 1'b0;
        end
    end

    // ==========================================================
    // Link control writes, only the root enable is held here
    assign lc_set = (wr && hit_ls) ? bus_req_in.wdata : '0;
    assign lc_clr = (wr && hit_lc) ? bus_req_in.wdata : '0;

    // ==========================================================
    // Whole state next value
    always_comb begin
        nxt_st = st_ff;
        nxt_st.filt = link_evt_pkg::w1sc(st_ff.filt,
            (wr && hit_fs) ? bus_req_in.wdata : '0,
            (wr && hit_fc) ? bus_req_in.wdata : '0);
        nxt_st.ev = ev_next;
        if (wr && hit_en) begin
            nxt_st.ena = bus_req_in.wdata;
        end
        if (lc_set[link_evt_pkg::ROOT_EN_BIT]) begin
            nxt_st.root_en = 1'b1;
        end else if (lc_clr[link_evt_pkg::ROOT_EN_BIT]) begin
            nxt_st.root_en = 1'b0;
        end
        // Hardware stop beats a software set in the same cycle
        if (overlong_pulse) begin
            nxt_st.root_en = 1'b0;
        end
        // Culprits follow live halts until the fatal flag latches
        if (st_ff.ev[link_evt_pkg::FATAL_BIT]) begin
            nxt_st.culprit = st_ff.culprit | halt_src_in;
        end else begin
            nxt_st.culprit = halt_src_in;
        end
        nxt_st.rdata = '0;
        if (rd) begin
            case (bus_req_in.addr)
                link_evt_pkg::FILT_SET_OFS: nxt_st.rdata = st_ff.filt;
                link_evt_pkg::FILT_CLR_OFS: nxt_st.rdata = st_ff.filt;
                link_evt_pkg::EV_SET_OFS: nxt_st.rdata = ev_view;
                link_evt_pkg::EV_CLR_OFS: nxt_st.rdata = ev_view & st_ff.ena;
                link_evt_pkg::ENA_OFS: nxt_st.rdata = st_ff.ena;
                link_evt_pkg::LCTL_SET_OFS,
                link_evt_pkg::LCTL_CLR_OFS: begin
                    nxt_st.rdata[link_evt_pkg::ROOT_EN_BIT] = st_ff.root_en;
                end
                default: nxt_st.rdata = '0;
            endcase
        end
        nxt_st.irq = |(ev_view & st_ff.ena);
    end

    // ==========================================================
    // State register; the clock enable freezes everything
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_ff <= link_evt_pkg::EVT_RST;
        end else if (ce_in) begin
            st_ff <= nxt_st;
        end
    end

    assign rd_data_out = st_ff.rdata;
    assign irq_out = st_ff.irq;
    assign chan_recv_allow_out = st_ff.filt;
    assign root_timing_source_enable_out = st_ff.root_en;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rstn_in);

    filt_set_a: assert property (ce_in && wr && hit_fs
        |=> (st_ff.filt & $past(bus_req_in.wdata)) == $past(bus_req_in.wdata))
        else $error("filter set write lost");
    filt_clr_a: assert property (ce_in && wr && hit_fc
        |=> (st_ff.filt & $past(bus_req_in.wdata)) == '0)
        else $error("filter clear write lost");
    filt_keep_a: assert property (ce_in && !(wr && (hit_fs || hit_fc))
        |=> $stable(st_ff.filt))
        else $error("filter changed without write");
    filt_read_a: assert property (ce_in && rd && (hit_fs || hit_fc)
        |=> rd_data_out == $past(st_ff.filt))
        else $error("filter read wrong");
    ev_set_a: assert property (ce_in && (hw_set | sw_set) != '0
        |=> ((st_ff.ev & $past(hw_set | sw_set)) | 32'h0001_0000)
            == ($past(hw_set | sw_set) | 32'h0001_0000))
        else $error("event set lost");
    ev_sticky_a: assert property (ce_in && !(wr && hit_ec)
        |=> ($past(st_ff.ev) & ~st_ff.ev & link_evt_pkg::STICKY_MASK) == '0)
        else $error("event cleared without clear write");
    masked_read_a: assert property (ce_in && rd && hit_ec
        |=> rd_data_out == ($past(ev_view) & $past(st_ff.ena)))
        else $error("masked event read wrong");
    rsvd_zero_a: assert property (ce_in && rd && (hit_es || hit_ec)
        |=> (rd_data_out & link_evt_pkg::RSVD_MASK) == '0)
        else $error("reserved event bits not zero");
    ro_write_a: assert property (ce_in && wr && (hit_es || hit_ec)
        |=> ((st_ff.ev ^ $past(st_ff.ev)) & ~link_evt_pkg::LATCH_MASK) == '0)
        else $error("read-only event bit written");
    phy_rb_a: assert property (ce_in && rise[link_evt_pkg::PHY_RB_BIT]
        && !blocked[link_evt_pkg::PHY_RB_BIT] |=> st_ff.ev[link_evt_pkg::PHY_RB_BIT])
        else $error("phy readback event missed");
    overlong_a: assert property (ce_in && overlong_pulse
        |=> st_ff.ev[link_evt_pkg::OVERLONG_BIT] && !st_ff.root_en)
        else $error("overlong cycle not handled");
    halt_a: assert property (ce_in && rise[link_evt_pkg::FATAL_BIT]
        |=> st_ff.ev[link_evt_pkg::FATAL_BIT])
        else $error("halt event missed");
    block_a: assert property (ce_in && st_ff.ev[link_evt_pkg::FATAL_BIT]
        && !(wr && hit_es) |=> (st_ff.ev & ~$past(st_ff.ev) & $past(blocked)) == '0)
        else $error("halted context event not blocked");
    mismatch_a: assert property (ce_in && mismatch
        && !blocked[link_evt_pkg::MISMATCH_BIT] |=> st_ff.ev[link_evt_pkg::MISMATCH_BIT])
        else $error("timer mismatch missed");
    summary_a: assert property (ce_in && rd && hit_es
        |=> rd_data_out[7:6] == $past({rx_sum, tx_sum}))
        else $error("iso summary bits wrong");
    reinit_a: assert property (ce_in && !st_ff.ev[link_evt_pkg::REINIT_BIT]
        && ev_next[link_evt_pkg::REINIT_BIT] |=> !st_ff.ev[link_evt_pkg::IDENT_BIT])
        else $error("ident done not cleared on bus reinit");
    irq_level_a: assert property (ce_in
        |=> irq_out == |($past(ev_view) & $past(st_ff.ena)))
        else $error("interrupt level wrong");

    filt_wr_c: cover property (ce_in && wr && hit_fs ##1 ce_in && rd && hit_fc);
    fatal_c: cover property (st_ff.ev[link_evt_pkg::FATAL_BIT] && (pulses & blocked) != '0);
    overlong_c: cover property (overlong_pulse ##1 !st_ff.root_en);
    irq_c: cover property (ce_in && rd && hit_ec ##1 rd_data_out != '0);

endmodule
`default_nettype wire

// File: logic/link_evt_pkg.sv
// Contract
// - Hold a 32-bit filter; bit n allows receive on channel n, 0 to 31.
// - Ones written at 78h set filter bits; ones at 7Ch clear them.
// - Reading either filter address returns the current filter.
// - Event bit sets on rising source edge or a one written at set address.
// - Latched event bits other than bit 16 clear only by a one written at the clear address.
// - Events set at 80h, cleared at 84h; read of 84h gives events AND enables.
// - Reserved event bits 31 and 29 to 27 read zero and ignore writes.
// - Bit 26 sets when a readback byte from the physical layer arrives.
// - As root, set bit 25 if over 125 us from cycle start to gap end.
// - The overlong cycle event clears the root timing enable, bit 21.
// - Bit 24 sets whenever an error halts any subunit.
// - While bit 24 is set, normal events of halted contexts cannot set.
// - Bit 23 sets when received seconds and count differ from local timer.
// - Bits 7 and 6 do not latch; they show masked iso context events.
// - Bit 16 clears in the same cycle that bit 17 becomes set.
package link_evt_pkg;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned OVERLONG_NS = 125000;
    // Longest time: rounds down
    localparam int unsigned OVERLONG_CYC = OVERLONG_NS / CLK_PERIOD_NS;
    localparam int unsigned CNT_W = 16;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] FILT_SET_OFS = 8'h78;
    localparam logic [7:0] FILT_CLR_OFS = 8'h7c;
    localparam logic [7:0] EV_SET_OFS = 8'h80;
    localparam logic [7:0] EV_CLR_OFS = 8'h84;
    localparam logic [7:0] ENA_OFS = 8'h88;
    localparam logic [7:0] LCTL_SET_OFS = 8'he0;
    localparam logic [7:0] LCTL_CLR_OFS = 8'he4;

    // ==========================================================
    // Field positions and masks
    localparam int MAKER_BIT = 30;
    localparam int PHY_RB_BIT = 26;
    localparam int OVERLONG_BIT = 25;
    localparam int FATAL_BIT = 24;
    localparam int MISMATCH_BIT = 23;
    localparam int ROOT_EN_BIT = 21;
    localparam int REINIT_BIT = 17;
    localparam int IDENT_BIT = 16;
    localparam int RX_SUM_BIT = 7;
    localparam int TX_SUM_BIT = 6;
    localparam int SECS_HI = 31;
    localparam int SECS_LO = 25;
    localparam int CNT_HI = 24;
    localparam int CNT_LO = 12;
    localparam logic [31:0] LATCH_MASK = 32'h07fb_033f;
    localparam logic [31:0] GEN_SRC_MASK = 32'h007b_033f;
    localparam logic [31:0] RSVD_MASK = 32'hb804_fc00;
    localparam logic [31:0] STICKY_MASK = 32'h07fa_033f;

    // ==========================================================
    // Types and reset values
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } bus_req_t;

    typedef enum logic [1:0] {
        OLC_IDLE = 2'b01,
        OLC_RUN = 2'b10
    } olc_mode_t;

    typedef struct packed {
        olc_mode_t mode;
        logic [CNT_W-1:0] cnt;
        logic fired;
    } olc_state_t;

    typedef struct packed {
        logic [31:0] prev;
    } edge_state_t;

    typedef struct packed {
        logic [31:0] filt;
        logic [31:0] ev;
        logic [31:0] ena;
        logic root_en;
        logic [31:0] culprit;
        logic [31:0] rdata;
        logic irq;
    } evt_state_t;

    localparam evt_state_t EVT_RST = '0;
    localparam edge_state_t EDGE_RST = '0;
    localparam olc_state_t OLC_RST = '{mode: OLC_IDLE, cnt: '0, fired: 1'b0};

    // Set wins over clear for every flag
    function automatic logic [31:0] w1sc(input logic [31:0] cur,
                                         input logic [31:0] set,
                                         input logic [31:0] clr);
        return (cur & ~clr) | set;
    endfunction

    // Seconds and count fields of a cycle stamp
    function automatic logic [19:0] timer_key(input logic [31:0] t);
        return {t[SECS_HI:SECS_LO], t[CNT_HI:CNT_LO]};
    endfunction

endpackage

// File: logic/rise_bank.sv
`timescale 1ns/1ns
`default_nettype none
module rise_bank (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire logic [31:0] lvl_in,
    output logic [31:0] rise_out
);

    link_evt_pkg::edge_state_t st_ff;
    link_evt_pkg::edge_state_t nxt_st;

    // ==========================================================
    // Rising edge per source
    always_comb begin
        nxt_st.prev = lvl_in;
    end

    assign rise_out = lvl_in & ~st_ff.prev;

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_ff <= link_evt_pkg::EDGE_RST;
        end else if (ce_in) begin
            st_ff <= nxt_st;
        end
    end

endmodule
`default_nettype wire

// File: logic/overlong_watch.sv
`timescale 1ns/1ns
`default_nettype none
module overlong_watch #(
    parameter int unsigned LIMIT = link_evt_pkg::OVERLONG_CYC
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire logic arm_in,
    input wire logic start_in,
    input wire logic gap_end_in,
    output logic expired_out
);

    localparam logic [link_evt_pkg::CNT_W-1:0] LIM = link_evt_pkg::CNT_W'(LIMIT);

    link_evt_pkg::olc_state_t st_ff;
    link_evt_pkg::olc_state_t nxt_st;

    // ==========================================================
    // Cycle start to gap end watchdog, root only
    always_comb begin
        nxt_st = st_ff;
        nxt_st.fired = 1'b0;
        unique case (st_ff.mode)
            link_evt_pkg::OLC_IDLE: begin
                if (start_in && arm_in) begin
                    nxt_st.mode = link_evt_pkg::OLC_RUN;
                    nxt_st.cnt = '0;
                end
            end
            link_evt_pkg::OLC_RUN: begin
                if (gap_end_in || !arm_in) begin
                    nxt_st.mode = link_evt_pkg::OLC_IDLE;
                end else if (st_ff.cnt == LIM) begin
                    nxt_st.fired = 1'b1;
                    nxt_st.mode = link_evt_pkg::OLC_IDLE;
                end else begin
                    nxt_st.cnt = st_ff.cnt + 1'b1;
                end
            end
            default: begin
                nxt_st = link_evt_pkg::OLC_RST;
            end
        endcase
    end

    assign expired_out = st_ff.fired;

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_ff <= link_evt_pkg::OLC_RST;
        end else if (ce_in) begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // Checks
    olc_fire_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        ce_in && st_ff.mode == link_evt_pkg::OLC_RUN && st_ff.cnt == LIM
        && !gap_end_in && arm_in |=> expired_out)
        else $error("overlong limit reached without event");
    olc_early_a: assert property (@(posedge clk_sys_in) disable iff (!rstn_in)
        $rose(expired_out) |-> $past(st_ff.cnt) == LIM)
        else $error("overlong event before limit");
    olc_fire_c: cover property (@(posedge clk_sys_in) disable iff (!rstn_in)
        expired_out);

endmodule
`default_nettype wire

// File: testbench/test_link_event_regs.sv
`timescale 1ns/1ns
`default_nettype none
module test_link_event_regs;
    // ============================================================
    // Short names for the register map, and a short watchdog limit
    localparam logic [7:0] A_FS = link_evt_pkg::FILT_SET_OFS;
    localparam logic [7:0] A_FC = link_evt_pkg::FILT_CLR_OFS;
    localparam logic [7:0] A_ES = link_evt_pkg::EV_SET_OFS;
    localparam logic [7:0] A_EC = link_evt_pkg::EV_CLR_OFS;
    localparam logic [7:0] A_EN = link_evt_pkg::ENA_OFS;
    localparam logic [7:0] A_LS = link_evt_pkg::LCTL_SET_OFS;
    localparam int OVL = 20;

    logic clk_sys_in = 1'b0;
    logic rstn_in, ce, irq, root_en, phy_rb, cyc_tx, gap_end, rx_cs, maker;
    link_evt_pkg::bus_req_t bus_req;
    logic [31:0] rd_data, chan_allow, evt_src, halt_src, rx_stamp, loc_timer;
    logic [31:0] rx_evt, rx_ena, tx_evt, tx_ena;
    int n_fail = 0;
    int n_compared = 0;

    // Clock: 100 MHz
    always #5 clk_sys_in = ~clk_sys_in;

    link_event_regs #(.OVERLONG_CYC(OVL)) u_dut (
        .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .ce_in(ce), .bus_req_in(bus_req),
        .rd_data_out(rd_data), .irq_out(irq), .chan_recv_allow_out(chan_allow),
        .root_timing_source_enable_out(root_en), .evt_src_in(evt_src),
        .phy_readback_arrived_in(phy_rb), .halt_src_in(halt_src), .cyc_start_tx_in(cyc_tx),
        .subaction_gap_end_in(gap_end), .rx_cycle_start_in(rx_cs),
        .rx_cycle_stamp_in(rx_stamp), .local_cycle_timer_in(loc_timer),
        .iso_rx_ctx_evt_in(rx_evt), .iso_rx_ctx_ena_in(rx_ena), .iso_tx_ctx_evt_in(tx_evt),
        .iso_tx_ctx_ena_in(tx_ena), .maker_defined_flag_in(maker)
    );

    // ============================================================
    // Shared helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Strobe drops one edge later, so back-to-back calls never collide
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys_in);
        bus_req <= '0;
    endtask

    // Data stand only in the cycle after the read edge
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge clk_sys_in);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
        @(posedge clk_sys_in);
        bus_req <= '0;
        #1;
        check(rd_data, exp, what);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask

    // One-cycle pulse: 0 cycle start sent, 1 gap end, else cycle start received
    task automatic pulse(input int k);
        @(posedge clk_sys_in);
        case (k)
            0: cyc_tx <= 1'b1;
            1: gap_end <= 1'b1;
            default: rx_cs <= 1'b1;
        endcase
        @(posedge clk_sys_in);
        cyc_tx <= 1'b0;
        gap_end <= 1'b0;
        rx_cs <= 1'b0;
    endtask

    // ============================================================
    // Scenarios
    task automatic t_filter();
        rd_chk(A_FS, 32'h0000_0000, "filter after reset");
        bus_wr(A_FS, 32'h8000_0001);
        bus_wr(A_FS, 32'h0001_0000);
        rd_chk(A_FC, 32'h8001_0001, "filter via clear address");
        check(chan_allow, 32'h8001_0001, "channel allow pins");
        bus_wr(A_FC, 32'h8000_0000);
        rd_chk(A_FS, 32'h0001_0001, "filter after clear");
        rd_chk(8'h40, 32'h0000_0000, "unmapped read");
    endtask

    // Clock enable low: a write in that window must leave no trace
    task automatic t_freeze();
        @(posedge clk_sys_in) ce <= 1'b0;
        bus_wr(A_FS, 32'h0000_0100);
        ce <= 1'b1;
        rd_chk(A_FS, 32'h0001_0001, "write ignored while frozen");
    endtask

    // Everything but bus reinit, so ident done is not forced low
    task automatic t_soft_events();
        bus_wr(A_ES, 32'hfffd_ffff);
        rd_chk(A_ES, 32'h07f9_033f, "software set view");
        rd_chk(A_EC, 32'h0000_0000, "masked view, no enables");
        bus_wr(A_EN, 32'h0300_0001);
        rd_chk(A_EC, 32'h0300_0001, "masked view");
        check({31'h0, irq}, 32'h1, "irq with enabled event");
        bus_wr(A_EC, 32'h0100_0000);
        rd_chk(A_ES, 32'h06f9_033f, "partial clear");
        bus_wr(A_EC, 32'h0200_0001);
        tick(2);
        check({31'h0, irq}, 32'h0, "irq after clear");
        bus_wr(A_EC, 32'hffff_ffff);
        rd_chk(A_ES, 32'h0000_0000, "all cleared");
    endtask

    task automatic t_hw_events();
        @(posedge clk_sys_in) evt_src <= 32'h0000_0001;
        rd_chk(A_ES, 32'h0000_0001, "source edge");
        bus_wr(A_EC, 32'h0000_0001);
        rd_chk(A_ES, 32'h0000_0000, "held level no reset");
        @(posedge clk_sys_in) phy_rb <= 1'b1;
        rd_chk(A_ES, 32'h0400_0000, "phy readback");
        rx_evt <= 32'h0000_0004;
        rx_ena <= 32'h0000_0004;
        tx_evt <= 32'h0000_0001;
        bus_wr(A_EC, 32'h0400_00c0);
        rd_chk(A_ES, 32'h0000_0080, "live receive summary");
        @(posedge clk_sys_in) tx_ena <= 32'h0000_0001;
        rd_chk(A_ES, 32'h0000_00c0, "live transmit summary");
        rx_evt <= 32'h0000_0000;
        tx_evt <= 32'h0000_0000;
        @(posedge clk_sys_in) evt_src <= 32'h0001_0000;
        rd_chk(A_ES, 32'h0001_0000, "ident done");
        evt_src <= 32'h0003_0000;
        maker <= 1'b1;
        rd_chk(A_ES, 32'h4002_0000, "reinit drops ident done");
        evt_src <= 32'h0000_0000;
        maker <= 1'b0;
        bus_wr(A_EC, 32'hffff_ffff);
    endtask

    // Only the seconds and count fields take part in the compare
    task automatic t_mismatch();
        loc_timer <= 32'h1234_5678;
        rx_stamp <= 32'h1234_5fff;
        pulse(2);
        rd_chk(A_ES, 32'h0000_0000, "stamp equal");
        rx_stamp <= 32'h1234_6678;
        pulse(2);
        rd_chk(A_ES, 32'h0080_0000, "count differs");
        bus_wr(A_EC, 32'h0080_0000);
        rx_stamp <= 32'h1434_5678;
        pulse(2);
        rd_chk(A_ES, 32'h0080_0000, "seconds differ");
        bus_wr(A_EC, 32'hffff_ffff);
    endtask

    task automatic t_fatal();
        @(posedge clk_sys_in) halt_src <= 32'h0000_0001;
        tick(2);
        @(posedge clk_sys_in) evt_src <= 32'h0000_0001;
        rd_chk(A_ES, 32'h0100_0000, "halted context blocked");
        halt_src <= 32'h0000_0000;
        evt_src <= 32'h0000_0000;
        bus_wr(A_EC, 32'hffff_ffff);
        @(posedge clk_sys_in) evt_src <= 32'h0000_0001;
        rd_chk(A_ES, 32'h0000_0001, "unblocked after clear");
        evt_src <= 32'h0000_0000;
        bus_wr(A_EC, 32'hffff_ffff);
    endtask

    task automatic t_overlong();
        bus_wr(A_LS, 32'h0020_0000);
        rd_chk(A_LS, 32'h0020_0000, "root enable set");
        pulse(0);
        tick(OVL / 2);
        pulse(1);
        tick(OVL + 10);
        rd_chk(A_ES, 32'h0000_0000, "gap end in time");
        pulse(0);
        tick(OVL - 4);
        rd_chk(A_ES, 32'h0000_0000, "not yet overlong");
        tick(8);
        rd_chk(A_ES, 32'h0200_0000, "overlong flagged");
        check({31'h0, root_en}, 32'h0, "root enable dropped");
    endtask

    // ============================================================
    // Verdict, reached from the main sequence or the watchdog
    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Whole run is well under a thousand cycles; 100 us is ample
    initial begin
        #100_000;
        n_fail++;
        finish_test();
    end

    // Main sequence; clock enable drops only inside the freeze scenario
    initial begin
        {rstn_in, phy_rb, cyc_tx, gap_end, rx_cs, maker} = '0;
        ce = 1'b1;
        bus_req = '0;
        {evt_src, halt_src, rx_stamp, loc_timer} = '0;
        {rx_evt, rx_ena, tx_evt, tx_ena} = '0;
        tick(20);
        rstn_in <= 1'b1;
        t_filter();
        t_freeze();
        t_soft_events();
        t_hw_events();
        t_mismatch();
        t_fatal();
        t_overlong();
        finish_test();
    end
endmodule
`default_nettype wire
